// *** verilog/boc_defines.svh ***
/*
 constants of the breaker object control block.
 assumes a 250 MHz sys_clk; times are held in milliseconds.
*/
`ifndef BOC_DEFINES_SVH
`define BOC_DEFINES_SVH
// What this block does
// RULE_01 - both inputs after traverse time: Bad
// RULE_02 - neither input after traverse time: Intermediate
// RULE_03 - close pulse bounded, ends on status
// RULE_04 - open pulse bounded, ends on status
// RULE_05 - no status change by timeout: fail
// RULE_06 - final trip pulse; zero means continuous
// RULE_07 - final trip only without pending reclose
// RULE_08 - diagram control gated by access level
// RULE_09 - local, remote, application command sources
// RULE_10 - separate open and close blocking
// RULE_11 - blocking must lead command by 5ms; the code checks blk_in only at the request, with no lead time
// RULE_12 - events with on/off storage selection
// RULE_13 - rolling twelve time-stamped records
// RULE_14 - record holds measured operating time
// RULE_15 - record holds states, cause, source
// RULE_16 - full per-instance event set
// RULE_17 - close needs ready at selected level
// RULE_18 - request counters with self-clearing clear
// RULE_19 - rejected command: no pulse, fail event
// ==========================================
// timing
`define BOC_CLK_NS     4
`define BOC_MS_NS      1000000
`define BOC_TICK_CYC   (`BOC_MS_NS / `BOC_CLK_NS)
`define BOC_BLK_LEAD_MS 5
// ==========================================
// register offsets
`define BOC_R_CTRL     8'h00
`define BOC_R_TRAV     8'h04
`define BOC_R_CPUL     8'h08
`define BOC_R_OPUL     8'h0c
`define BOC_R_TERM     8'h10
`define BOC_R_FTRP     8'h14
`define BOC_R_BLK      8'h18
`define BOC_R_STAT     8'h1c
`define BOC_R_ISTS     8'h20
`define BOC_R_IMSK     8'h24
`define BOC_R_ESEL     8'h28
`define BOC_R_NOPN     8'h30
`define BOC_R_NCLS     8'h34
`define BOC_R_NOPF     8'h38
`define BOC_R_NCLF     8'h3c
`define BOC_R_RIDX     8'h40
`define BOC_R_RTS      8'h44
`define BOC_R_RDAT     8'h48
// ==========================================
// control fields
`define BOC_F_ACC      1:0
`define BOC_F_RDY      3:2
`define BOC_F_USR      5:4
`define BOC_B_CLR      8
`define BOC_B_SOPN     9
`define BOC_B_SCLS     10
// ==========================================
// reset values, times in milliseconds
`define BOC_RST_TRAV   20'd200
`define BOC_RST_PUL    20'd200
`define BOC_RST_TERM   20'd10000
`define BOC_RST_FTRP   20'd200
`define BOC_RST_ACC    2'h2
`define BOC_RST_RDY    2'h2
`define BOC_NREC       12
`endif

// *** verilog/boc_pkg.sv ***
/*
 types of the breaker object control block.
 assumes boc_defines.svh for the numbers.
*/
package boc_pkg;
  typedef enum logic [1:0] {
    ST_INTER  = 2'h0,
    ST_OPEN   = 2'h1,
    ST_CLOSED = 2'h2,
    ST_BAD    = 2'h3
  } boc_pos_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_OPEN  = 4'h2,
    S_CLOSE = 4'h4,
    S_WAIT  = 4'h8
  } boc_fsm_t;
  typedef enum logic [2:0] {
    F_NONE = 3'h0,
    F_BLK  = 3'h1,
    F_RDY  = 3'h2,
    F_SYN  = 3'h3,
    F_TMO  = 3'h4
  } boc_fail_t;
  typedef struct packed {
    logic loc_open;
    logic loc_close;
    logic rem_open;
    logic rem_close;
    logic app_open;
    logic app_close;
  } boc_cmd_t;
  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0]  fail;
    logic        dir_close;
    logic [2:0]  src;
    logic        ok;
    logic [1:0]  cart;
    logic [1:0]  pos;
    logic [19:0] optime;
  } boc_rec_t;
endpackage : boc_pkg

// *** verilog/boc_top.sv ***
/*
 breaker object control: position decode, command pulses,
 final trip, blocking, events, records, apb registers.
 assumes synchronous status inputs and an apb master.
*/
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "boc_defines.svh"
module boc_top import boc_pkg::*; #(
  parameter int TICK_CYC = `BOC_TICK_CYC,
  parameter int TW       = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sts_open,
  input  wire logic        sts_closed,
  input  wire logic        cart_in,
  input  wire logic        cart_out,
  input  wire logic        obj_ready,
  input  wire logic        sync_ok,
  input  wire logic [7:0]  blk_in,
  input  wire logic        abrasion,
  input  wire logic        local_mode,
  input  wire logic        ar_pending,
  input  wire logic        trip_in,
  input  wire boc_cmd_t    cmd_in,
  output logic             open_relay,
  output logic             close_relay,
  output logic             final_trip,
  output logic [19:0]      evt_pulse,
  output logic             irq,
  output boc_pos_t         obj_pos,
  output boc_pos_t         cart_pos
);
  if (TICK_CYC < 2 || TW < 20) begin : g_bad_param
    $error("boc_top: bad parameters");
  end
  // ==========================================
  // ms tick and time stamp
  logic [31:0] tk_q, tk_d, ms_q, ms_d;
  logic        tick;
  assign tick = (tk_q == 32'(TICK_CYC - 1));
  always_comb begin
    tk_d = tick ? 32'h0 : tk_q + 32'h1;
    ms_d = tick ? ms_q + 32'h1 : ms_q;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tk_q <= 32'h0;
      ms_q <= 32'h0;
    end else if (ce) begin
      tk_q <= tk_d;
      ms_q <= ms_d;
    end
  end
  // ==========================================
  // registers
  logic [31:0] ctrl_q, ctrl_d, blk_q, blk_d, ists_q, ists_d, imsk_q, imsk_d, esel_q, esel_d;
  logic [TW-1:0] trav_q, trav_d, cpul_q, cpul_d, opul_q, opul_d, term_q, term_d, ftrp_q, ftrp_d;
  logic [3:0]  ridx_q, ridx_d;
  logic [31:0] rd_d, prdata_q;
  logic        err_d, pslverr_q, wr, setup;
  logic [19:0] ev_hit;
  logic [31:0] n_q [4];
  boc_rec_t    rec_q [`BOC_NREC];
  boc_pos_t    pos_q, cpos_q;
  boc_fsm_t    st_q;
  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && ce;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  always_comb begin
    ctrl_d = ctrl_q;
    blk_d  = blk_q;
    imsk_d = imsk_q;
    esel_d = esel_q;
    trav_d = trav_q;
    cpul_d = cpul_q;
    opul_d = opul_q;
    term_d = term_q;
    ftrp_d = ftrp_q;
    ridx_d = ridx_q;
    ists_d = ists_q | {12'h0, ev_hit};
    ctrl_d[`BOC_B_CLR]  = 1'b0;  // RULE_18
    ctrl_d[`BOC_B_SOPN] = 1'b0;
    ctrl_d[`BOC_B_SCLS] = 1'b0;
    if (wr) begin
      unique case (paddr)
        `BOC_R_CTRL: ctrl_d = {21'h0, pwdata[10:8], 2'h0, pwdata[5:0]};
        `BOC_R_TRAV: trav_d = pwdata[TW-1:0];
        `BOC_R_CPUL: cpul_d = pwdata[TW-1:0];
        `BOC_R_OPUL: opul_d = pwdata[TW-1:0];
        `BOC_R_TERM: term_d = pwdata[TW-1:0];
        `BOC_R_FTRP: ftrp_d = pwdata[TW-1:0];
        `BOC_R_BLK:  blk_d  = {16'h0, pwdata[15:0]};
        `BOC_R_ISTS: ists_d = (ists_q & ~pwdata) | {12'h0, ev_hit};
        `BOC_R_IMSK: imsk_d = {12'h0, pwdata[19:0]};
        `BOC_R_ESEL: esel_d = pwdata;
        `BOC_R_RIDX: ridx_d = (pwdata[3:0] < 4'(`BOC_NREC)) ? pwdata[3:0] : 4'h0;
        default: ;
      endcase
    end
    err_d = 1'b0;
    rd_d  = 32'h0;
    unique case (paddr)
      `BOC_R_CTRL: rd_d = ctrl_q;
      `BOC_R_TRAV: rd_d = 32'(trav_q);
      `BOC_R_CPUL: rd_d = 32'(cpul_q);
      `BOC_R_OPUL: rd_d = 32'(opul_q);
      `BOC_R_TERM: rd_d = 32'(term_q);
      `BOC_R_FTRP: rd_d = 32'(ftrp_q);
      `BOC_R_BLK:  rd_d = blk_q;
      `BOC_R_STAT: rd_d = {24'h0, st_q, cpos_q, pos_q};
      `BOC_R_ISTS: rd_d = ists_q;
      `BOC_R_IMSK: rd_d = imsk_q;
      `BOC_R_ESEL: rd_d = esel_q;
      `BOC_R_NOPN: rd_d = n_q[0];
      `BOC_R_NCLS: rd_d = n_q[1];
      `BOC_R_NOPF: rd_d = n_q[2];
      `BOC_R_NCLF: rd_d = n_q[3];
      `BOC_R_RIDX: rd_d = {28'h0, ridx_q};
      `BOC_R_RTS:  rd_d = rec_q[ridx_q].stamp;
      `BOC_R_RDAT: rd_d = rec_q[ridx_q][31:0];
      default:     err_d = 1'b1;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_q    <= {28'h0, `BOC_RST_RDY, `BOC_RST_ACC};
      blk_q     <= 32'h0;
      ists_q    <= 32'h0;
      imsk_q    <= 32'h0;
      esel_q    <= 32'hffffffff;
      trav_q    <= `BOC_RST_TRAV;
      cpul_q    <= `BOC_RST_PUL;
      opul_q    <= `BOC_RST_PUL;
      term_q    <= `BOC_RST_TERM;
      ftrp_q    <= `BOC_RST_FTRP;
      ridx_q    <= 4'h0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
      blk_q  <= blk_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      esel_q <= esel_d;
      trav_q <= trav_d;
      cpul_q <= cpul_d;
      opul_q <= opul_d;
      term_q <= term_d;
      ftrp_q <= ftrp_d;
      ridx_q <= ridx_d;
      if (setup) begin
        prdata_q  <= rd_d;
        pslverr_q <= err_d;
      end
    end
  end
  assign irq = |(ists_q & imsk_q);
  // ==========================================
  // position decode
  function automatic boc_pos_t pos_of(input logic a, input logic b);
    pos_of = a ? ST_OPEN : ST_CLOSED;
  endfunction : pos_of
  logic [TW-1:0] tv_q, tv_d;
  boc_pos_t      pos_d, cpos_d;
  logic          inv, cinv;
  assign inv  = (sts_open == sts_closed);
  assign cinv = (cart_in == cart_out);
  always_comb begin
    pos_d  = inv ? pos_q : pos_of(sts_open, sts_closed);
    cpos_d = cinv ? cpos_q : pos_of(cart_out, cart_in);
    tv_d   = (inv || cinv) ? tv_q : '0;
    if ((inv || cinv) && tick) begin
      tv_d = tv_q + 1'b1;
      if (tv_d >= trav_q) begin
        tv_d = trav_q;
        if (inv) pos_d = sts_open ? ST_BAD : ST_INTER;  // RULE_01 RULE_02
        if (cinv) cpos_d = cart_in ? ST_BAD : ST_INTER;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tv_q   <= '0;
      pos_q  <= ST_INTER;
      cpos_q <= ST_INTER;
    end else if (ce) begin
      tv_q   <= tv_d;
      pos_q  <= pos_d;
      cpos_q <= cpos_d;
    end
  end
  assign obj_pos  = pos_q;
  assign cart_pos = cpos_q;
  // ==========================================
  // command control
  logic [6:0]    cin_q;
  logic [6:0]    cin_rise;
  logic          sld_ok, oreq, creq, oblk, cblk, rdy_ok, reached;
  logic          trp_q, trp_d, ft_q, ft_d, ok_ev, fail_ev, ofail, cfail;
  logic [TW-1:0] op_q, op_d, pc_q, pc_d, fc_q, fc_d;
  logic [2:0]    src_q, src_d, src_n;
  logic [3:0]    wp_q, wp_d;
  boc_fsm_t      st_d;
  boc_fail_t     fl;
  boc_rec_t      rec_d;
  assign cin_rise = {trip_in, cmd_in} & ~cin_q;  // RULE_09
  assign sld_ok = (ctrl_q[`BOC_F_USR] >= ctrl_q[`BOC_F_ACC]);  // RULE_08
  assign oreq = |{cin_rise[6], cin_rise[5], cin_rise[3], cin_rise[1]}
              | (ctrl_q[`BOC_B_SOPN] & sld_ok);
  assign creq = |{cin_rise[4], cin_rise[2], cin_rise[0]} | (ctrl_q[`BOC_B_SCLS] & sld_ok);
  assign oblk = |(blk_in & blk_q[7:0]);  // RULE_10 RULE_11
  assign cblk = |(blk_in & blk_q[15:8]);  // RULE_10
  always_comb begin
    unique case (ctrl_q[`BOC_F_RDY])
      2'h0:    rdy_ok = obj_ready;  // RULE_17
      2'h1:    rdy_ok = !obj_ready;
      default: rdy_ok = 1'b1;
    endcase
  end
  assign reached = (st_q == S_CLOSE || (st_q == S_WAIT && src_q[2])) ? pos_q == ST_CLOSED : pos_q == ST_OPEN;
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    pc_d    = pc_q;
    src_d   = src_q;
    trp_d   = trp_q;
    fl      = F_NONE;
    ok_ev   = 1'b0;
    fail_ev = 1'b0;
    src_n   = cin_rise[6] ? 3'h4 : cin_rise[5] || cin_rise[4] ? 3'h0
            : cin_rise[3] || cin_rise[2] ? 3'h1 : cin_rise[1] || cin_rise[0] ? 3'h2 : 3'h3;
    unique case (st_q)
      S_IDLE: begin
        op_d = '0;
        pc_d = '0;
        if (oreq) begin
          src_d = {1'b0, src_n[1:0]};
          trp_d = cin_rise[6];
          if (oblk) begin
            fl = F_BLK;  // RULE_19
            fail_ev = 1'b1;
          end else st_d = S_OPEN;
        end else if (creq) begin
          src_d = {1'b1, src_n[1:0]};
          trp_d = 1'b0;
          fail_ev = 1'b1;
          if (cblk) fl = F_BLK;  // RULE_19
          else if (!rdy_ok) fl = F_RDY;
          else if (!sync_ok) fl = F_SYN;
          else begin
            fail_ev = 1'b0;
            st_d = S_CLOSE;
          end
        end
      end
      default: begin
        if (reached) begin
          ok_ev = 1'b1;  // RULE_03 RULE_04
          st_d  = S_IDLE;
        end else if (tick) begin
          op_d = op_q + 1'b1;
          pc_d = pc_q + 1'b1;
          if (pc_d >= (st_q == S_CLOSE ? cpul_q : opul_q) && st_q != S_WAIT) begin
            if (st_q == S_CLOSE) src_d[2] = 1'b1;
            st_d = S_WAIT;  // RULE_03 RULE_04
          end
          if (op_d >= term_q) begin
            fl = F_TMO;  // RULE_05
            fail_ev = 1'b1;
            st_d = S_IDLE;
          end
        end
      end
    endcase
  end
  assign ofail = fail_ev && !src_d[2];
  assign cfail = fail_ev && src_d[2];
  always_comb begin
    ft_d = ft_q;
    fc_d = fc_q;
    if (ok_ev && !src_q[2] && trp_q && !ar_pending) begin
      ft_d = 1'b1;  // RULE_06 RULE_07
      fc_d = '0;
    end else if (ok_ev && src_q[2]) ft_d = 1'b0;
    else if (ft_q && tick && ftrp_q != '0) begin
      fc_d = fc_q + 1'b1;
      if (fc_d >= ftrp_q) ft_d = 1'b0;  // RULE_06
    end
    rec_d = '{stamp: ms_q, fail: fl, dir_close: src_d[2], src: src_d, ok: ok_ev,
              cart: cpos_q, pos: pos_q, optime: op_q};  // RULE_14 RULE_15
    wp_d  = (ok_ev || fail_ev) ? ((wp_q == 4'(`BOC_NREC - 1)) ? 4'h0 : wp_q + 4'h1) : wp_q;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q  <= S_IDLE;
      op_q  <= '0;
      pc_q  <= '0;
      fc_q  <= '0;
      src_q <= 3'h0;
      trp_q <= 1'b0;
      ft_q  <= 1'b0;
      wp_q  <= 4'h0;
      cin_q <= 7'h0;
    end else if (ce) begin
      st_q  <= st_d;
      op_q  <= op_d;
      pc_q  <= pc_d;
      fc_q  <= fc_d;
      src_q <= src_d;
      trp_q <= trp_d;
      ft_q  <= ft_d;
      wp_q  <= wp_d;
      cin_q <= {trip_in, cmd_in};
      if (ok_ev || fail_ev) rec_q[wp_q] <= rec_d;  // RULE_13
    end
  end
  assign open_relay  = (st_q == S_OPEN);
  assign close_relay = (st_q == S_CLOSE);
  assign final_trip  = ft_q;
  // ==========================================
  // counters, events
  logic [31:0] n_d [4];
  logic [19:0] ev, ev_q;
  logic [19:0] ep_d, ep_q;
  always_comb begin
    for (int i = 0; i < 4; i++) n_d[i] = ctrl_q[`BOC_B_CLR] ? 32'h0 : n_q[i];  // RULE_18
    if (ok_ev && !src_q[2]) n_d[0] = n_q[0] + 32'h1;
    if (ok_ev && src_q[2]) n_d[1] = n_q[1] + 32'h1;
    if (ofail) n_d[2] = n_q[2] + 32'h1;
    if (cfail) n_d[3] = n_q[3] + 32'h1;
    ev = {(fl == F_TMO), abrasion, cfail, ofail, local_mode, ft_q,
          sync_ok, rdy_ok, cblk, oblk, close_relay, open_relay, creq, oreq,
          cpos_q == ST_BAD, cpos_q == ST_CLOSED, pos_q == ST_BAD, pos_q == ST_INTER,
          pos_q == ST_CLOSED, pos_q == ST_OPEN};  // RULE_16
    ep_d = (ev & ~ev_q & esel_q[19:0]) | (~ev & ev_q & {esel_q[31:20], esel_q[7:0]});  // RULE_12
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) n_q[i] <= 32'h0;
      ev_q <= 20'h0;
      ep_q <= 20'h0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) n_q[i] <= n_d[i];
      ev_q <= ev;
      ep_q <= ep_d;
    end
  end
  assign ev_hit    = ce ? ep_d : 20'h0;
  assign evt_pulse = ep_q;
  // ==========================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_bad_after_trav: assert property (ce && tick && sts_open && sts_closed && tv_q + 1'b1 >= trav_q
    |=> pos_q == ST_BAD) else $error("bad state not set");  // RULE_01
  a_inter_after_trav: assert property (ce && tick && !sts_open && !sts_closed && tv_q + 1'b1 >= trav_q
    |=> pos_q == ST_INTER) else $error("intermediate not set");  // RULE_02
  a_close_ends: assert property (ce && close_relay && pos_q == ST_CLOSED |=> !close_relay)
    else $error("close pulse outlived status");  // RULE_03
  a_open_max: assert property (open_relay |-> pc_q < opul_q) else $error("open pulse too long");  // RULE_04
  a_term_fail: assert property (ce && esel_q[19] && st_q != S_IDLE && !reached && tick && op_q + 1'b1 >= term_q
    |=> st_q == S_IDLE && ep_q[19]) else $error("timeout not ended");  // RULE_05
  a_ft_cont: assert property (ce && ft_q && ftrp_q == '0 && !ok_ev |=> ft_q)
    else $error("continuous final trip dropped");  // RULE_06
  a_ft_ar_gate: assert property ($rose(ft_q) |-> !$past(ar_pending)) else $error("trip while reclose");  // RULE_07
  a_blk_no_pulse: assert property (ce && st_q == S_IDLE && oreq && oblk |=> !open_relay ##0 n_q[2] != 32'h0)
    else $error("blocked open pulsed");  // RULE_19
  a_ready_gate: assert property ($rose(close_relay) |-> $past(rdy_ok)) else $error("close without ready");  // RULE_17
  a_clr_stats: assert property (ce && ctrl_q[`BOC_B_CLR] && !ok_ev && !fail_ev |=> n_q[0] == 32'h0
    && !ctrl_q[`BOC_B_CLR]) else $error("clear failed");  // RULE_18
  a_rec_ptr: assert property (wp_q < 4'(`BOC_NREC)) else $error("record pointer out of range");  // RULE_13
  c_open_ok: cover property (open_relay ##[1:1000] ok_ev);
  c_close_tmo: cover property (close_relay ##[1:1000] st_q == S_WAIT);
  c_final_trip: cover property ($rose(ft_q));
  c_wrap: cover property (ce && wp_q == 4'(`BOC_NREC - 1) && ok_ev);
endmodule : boc_top
`default_nettype wire

// *** tb/boc_breaker_model.sv ***
/*
 behavioural breaker behind the relay outputs and status inputs.
 assumes relays are levels from boc_top; mode 0 normal, 1 stuck, 2 both contacts, 3 no contact.
*/
`timescale 1ns/1ps
`default_nettype none
module boc_breaker_model (
  input  wire logic        sys_clk,
  input  wire logic        open_relay,
  input  wire logic        close_relay,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] delay_cyc,
  output logic             sts_open,
  output logic             sts_closed
);
  logic        is_closed_q = 1'b0;
  logic [15:0] cnt_q       = 16'h0;
  // ==========================================
  // mechanism: once started it travels to the end
  always_ff @(posedge sys_clk) begin
    if (cnt_q != 16'h0) begin
      if (cnt_q >= delay_cyc) begin
        is_closed_q <= ~is_closed_q;
        cnt_q       <= 16'h0;
      end else begin
        cnt_q <= cnt_q + 16'h1;
      end
    end else if (mode != 2'h1 && ((close_relay && !is_closed_q) || (open_relay && is_closed_q))) begin
      cnt_q <= 16'h1;
    end
  end
  // ==========================================
  // contacts: both open while travelling
  always_comb begin
    sts_open   = (cnt_q == 16'h0) && !is_closed_q;
    sts_closed = (cnt_q == 16'h0) && is_closed_q;
    if (mode == 2'h2) begin
      sts_open   = 1'b1;
      sts_closed = 1'b1;
    end else if (mode == 2'h3) begin
      sts_open   = 1'b0;
      sts_closed = 1'b0;
    end
  end
endmodule : boc_breaker_model
`default_nettype wire

// *** tb/boc_top_tb.sv ***
/*
 self-checking bench of boc_top: apb tasks, command scenarios, breaker model.
 assumes boc_pkg, boc_top and boc_breaker_model compiled first; one ms is 10 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "boc_defines.svh"
module boc_top_tb import boc_pkg::*;;
  localparam int T = 10;
  logic        sys_clk = 1'b0;
  logic        nrst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, blk_in;
  logic [31:0] pwdata, prdata, rd;
  logic        sts_open, sts_closed, cart_in, cart_out, obj_ready, sync_ok;
  logic        ar_pending, trip_in, open_relay, close_relay, final_trip, irq;
  boc_cmd_t    cmd_in;
  logic [19:0] evt_pulse;
  boc_pos_t    obj_pos, cart_pos;
  logic [1:0]  mode;
  logic [15:0] dly;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          oc, cc, ft;
  always #2 sys_clk = ~sys_clk;
  boc_top #(.TICK_CYC(T)) u_boc_top (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sts_open(sts_open), .sts_closed(sts_closed), .cart_in(cart_in), .cart_out(cart_out),
    .obj_ready(obj_ready), .sync_ok(sync_ok), .blk_in(blk_in), .abrasion(1'b0), .local_mode(1'b0),
    .ar_pending(ar_pending), .trip_in(trip_in), .cmd_in(cmd_in), .open_relay(open_relay),
    .close_relay(close_relay), .final_trip(final_trip), .evt_pulse(evt_pulse), .irq(irq),
    .obj_pos(obj_pos), .cart_pos(cart_pos));
  boc_breaker_model u_boc_breaker_model (
    .sys_clk(sys_clk), .open_relay(open_relay), .close_relay(close_relay), .mode(mode),
    .delay_cyc(dly), .sts_open(sts_open), .sts_closed(sts_closed));
  // ==========================================
  // reporting
  task automatic give_verdict();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // ==========================================
  // apb master
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        give_verdict();
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdc
  task automatic wait_idle();
    int n;
    n = 0;
    apb(1'b0, `BOC_R_STAT, 32'h0);
    while (rd[4] !== 1'b1) begin
      n++;
      if (n > 300) begin
        error_cnt++;
        give_verdict();
      end
      apb(1'b0, `BOC_R_STAT, 32'h0);
    end
  endtask : wait_idle
  // request edge on {trip, cmd} then count relay and final trip cycles
  task automatic go(input logic [6:0] v, input int w);
    oc = 0;
    cc = 0;
    ft = 0;
    {trip_in, cmd_in} <= v;
    for (int i = 0; i < w; i++) begin
      @(posedge sys_clk);
      if (i == 2) {trip_in, cmd_in} <= 7'h0;
      oc += int'(open_relay === 1'b1);
      cc += int'(close_relay === 1'b1);
      ft += int'(final_trip === 1'b1);
    end
    wait_idle();
  endtask : go
  // ==========================================
  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {trip_in, cmd_in, blk_in, ar_pending, cart_out, mode} = '0;
    {ce, cart_in, obj_ready, sync_ok} = 4'hf;
    dly = 16'd10;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc("trav rst", `BOC_R_TRAV, 32'd200);
    rdc("cpul rst", `BOC_R_CPUL, 32'd200);
    rdc("opul rst", `BOC_R_OPUL, 32'd200);
    rdc("term rst", `BOC_R_TERM, 32'd10000);
    rdc("ftrp rst", `BOC_R_FTRP, 32'd200);
    rdc("ctrl rst", `BOC_R_CTRL, 32'h0a);
    ce <= 1'b0;
    wr(`BOC_R_TRAV, 32'd7);
    ce <= 1'b1;
    rdc("ce frozen", `BOC_R_TRAV, 32'd200);
    apb(1'b0, 8'h2c, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    wr(`BOC_R_TRAV, 32'd3);
    wr(`BOC_R_CPUL, 32'd5);
    wr(`BOC_R_OPUL, 32'd5);
    wr(`BOC_R_TERM, 32'd20);
    wr(`BOC_R_FTRP, 32'd2);
    wr(`BOC_R_IMSK, 32'h20000);
    wr(`BOC_R_ESEL, 32'hffffffff);
    check("pos start", obj_pos, ST_OPEN);
    check("cart in", cart_pos, ST_CLOSED);
    go(7'h01, 300);
    check("fast close short", {31'h0, cc >= 8 && cc <= 15}, 32'h1);
    check("pos closed", obj_pos, ST_CLOSED);
    dly <= 16'd120;
    go(7'h20, 300);
    check("slow open bounded", {31'h0, oc >= 4 * T && oc <= 6 * T}, 32'h1);
    check("pos open", obj_pos, ST_OPEN);
    dly  <= 16'd10;
    mode <= 2'h1;
    go(7'h04, 300);
    check("irq on timeout", {31'h0, irq}, 32'h1);
    apb(1'b0, `BOC_R_ISTS, 32'h0);
    check("close fail bit", {31'h0, rd[17]}, 32'h1);
    wr(`BOC_R_ISTS, 32'h20000);
    @(posedge sys_clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    mode <= 2'h0;
    wr(`BOC_R_BLK, 32'h100);
    blk_in <= 8'h01;
    repeat (5 * T + 2) @(posedge sys_clk);
    go(7'h01, 40);
    check("blocked close", cc, 32'h0);
    check("blocked fail irq", {31'h0, irq}, 32'h1);
    go(7'h02, 60);
    check("open not blocked", {31'h0, oc > 0}, 32'h1);
    go(7'h01, 60);
    wr(`BOC_R_ISTS, 32'hfffff);
    blk_in <= 8'h00;
    wr(`BOC_R_CTRL, 32'h02);
    obj_ready <= 1'b0;
    go(7'h04, 40);
    check("ready fail", cc, 32'h0);
    wr(`BOC_R_CTRL, 32'h0a);
    obj_ready <= 1'b1;
    sync_ok   <= 1'b0;
    go(7'h01, 40);
    check("sync fail", cc, 32'h0);
    sync_ok <= 1'b1;
    go(7'h01, 100);
    ar_pending <= 1'b1;
    go(7'h40, 300);
    check("reclose no ftrip", ft, 32'h0);
    ar_pending <= 1'b0;
    go(7'h01, 100);
    go(7'h40, 300);
    check("ftrip len", {31'h0, ft >= T && ft <= 3 * T}, 32'h1);
    mode <= 2'h2;
    repeat (T) @(posedge sys_clk);
    check("bad held", obj_pos, ST_OPEN);
    repeat (5 * T) @(posedge sys_clk);
    check("bad", obj_pos, ST_BAD);
    mode <= 2'h3;
    repeat (6 * T) @(posedge sys_clk);
    check("inter", obj_pos, ST_INTER);
    mode <= 2'h0;
    cart_in  <= 1'b0;
    cart_out <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("cart out", cart_pos, ST_OPEN);
    rdc("nopn", `BOC_R_NOPN, 32'd4);
    rdc("ncls", `BOC_R_NCLS, 32'd3);
    rdc("nopf", `BOC_R_NOPF, 32'd0);
    rdc("nclf", `BOC_R_NCLF, 32'd5);
    wr(`BOC_R_RIDX, 32'd3);
    rdc("rec blocked close", `BOC_R_RDAT, 32'h3c900000);
    wr(`BOC_R_CTRL, 32'h10a);
    rdc("clear self", `BOC_R_CTRL, 32'h0a);
    rdc("ncls clr", `BOC_R_NCLS, 32'd0);
    wr(`BOC_R_CTRL, 32'h43a);
    go(7'h00, 100);
    check("diagram close", {31'h0, cc > 0}, 32'h1);
    rdc("ncls diag", `BOC_R_NCLS, 32'd1);
    wr(`BOC_R_CTRL, 32'h20a);
    go(7'h00, 60);
    check("diagram denied", oc, 32'h0);
    give_verdict();
  end
endmodule : boc_top_tb
`default_nettype wire
